// File: core/trs_map.svh
// timing constants and reset values for the triple rail sequencer
`ifndef TRS_MAP_SVH
`define TRS_MAP_SVH
`define TRS_CLK_HZ 20000000
`define TRS_BOOST_HZ 250000
// cycles of one boost period at the core clock
`define TRS_BOOST_PERIOD (`TRS_CLK_HZ / `TRS_BOOST_HZ)
// maximum duty in percent, inside the 79..92 window
`define TRS_MAX_DUTY_PCT 85
`define TRS_MAX_ON ((`TRS_BOOST_PERIOD * `TRS_MAX_DUTY_PCT) / 100)
`define TRS_SOFT_MS 16
// soft-start ramp length: longest time, rounds down
`define TRS_SOFT_CYC ((`TRS_CLK_HZ / 1000) * `TRS_SOFT_MS)
`define TRS_RAMP_STEPS 256
`define TRS_RDY_OFF 1'b0
`endif

// File: core/trs_pkg.sv
// types shared by the triple rail sequencer
package trs_pkg;
  typedef enum logic [5:0] {
    TRS_OFF = 6'h01,
    TRS_REF = 6'h02,
    TRS_MAIN = 6'h04,
    TRS_NEG = 6'h08,
    TRS_POS = 6'h10,
    TRS_READY = 6'h20
  } trs_state_e;

  // threshold comparator results, high when the condition named holds
  typedef struct packed {
    logic ref_ok;
    logic main_reg;
    logic main_fault;
    logic neg_up;
    logic neg_fault;
    logic pos_up;
    logic pos_fault;
  } trs_cmp_s;

  // rail enables
  typedef struct packed {
    logic ref_en;
    logic ref_ground;
    logic main_en;
    logic neg_en;
    logic pos_en;
  } trs_en_s;

  // switch gates of the two pumps, high side and low side
  typedef struct packed {
    logic neg_hi;
    logic neg_lo;
    logic pos_hi;
    logic pos_lo;
  } trs_pump_s;
endpackage

// File: core/trs_soft_start.sv
// soft-start ramp for one charge pump
`timescale 1ns/1ps
`include "trs_map.svh"
module trs_soft_start
  import trs_pkg::*;
(
  input wire logic clock,
  input wire logic reset,
  input wire logic enable,
  output logic [7:0] level,
  output logic done
);
  localparam int unsigned STEP_CYC = `TRS_SOFT_CYC / `TRS_RAMP_STEPS;
  logic [12:0] div_r;
  logic [7:0] level_r;
  logic done_r;

  // ================================================
  // ramp: full scale reached in no more than the soft window
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      div_r <= 13'h0;
      level_r <= 8'h0;
      done_r <= 1'b0;
    end else if (!enable) begin
      div_r <= 13'h0;
      level_r <= 8'h0;
      done_r <= 1'b0;
    end else if (!done_r) begin
      if (div_r == 13'(STEP_CYC - 1)) begin
        div_r <= 13'h0;
        level_r <= level_r + 8'h1;
        done_r <= (level_r == 8'hfe);
      end else begin
        div_r <= div_r + 13'h1;
      end
    end
  end

  assign level = level_r;
  assign done = done_r;
endmodule // trs_soft_start

// File: core/trs_sequencer.sv
// power-up sequencer, boost pwm timing and pump phases
`timescale 1ns/1ps
`include "trs_map.svh"
module trs_sequencer
  import trs_pkg::*;
(
  input wire logic clock,
  input wire logic reset,
  input wire logic shutdown_n,
  input wire trs_cmp_s cmp_in,
  input wire logic boost_trip,
  output trs_en_s rail_en,
  output logic boost_switch_node,
  output trs_pump_s pump_gate,
  output logic [7:0] neg_pump_ramp,
  output logic [7:0] pos_pump_ramp,
  output logic neg_pump_drive,
  output logic pos_pump_drive,
  output logic ready_n_o,
  output logic ready_n_oe,
  output trs_state_e seq_state
);
  localparam int unsigned PERIOD = `TRS_BOOST_PERIOD;
  localparam int unsigned HALF = PERIOD / 2;
  localparam int unsigned MAX_ON = `TRS_MAX_ON;

  // ================================================
  // input synchronisers
  // width of the synchronised bundle: comparators, trip, shutdown
  localparam int unsigned NSYNC = $bits(trs_cmp_s) + 2;
  logic [NSYNC-1:0] sync1_r;
  logic [NSYNC-1:0] sync2_r;
  logic [NSYNC-1:0] raw_in;
  trs_cmp_s cmp;
  logic trip_s;
  logic run_s;

  assign raw_in = {cmp_in, boost_trip, shutdown_n};

  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi++) begin : g_sync
      always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
          sync1_r[gi] <= 1'b0;
          sync2_r[gi] <= 1'b0;
        end else begin
          sync1_r[gi] <= raw_in[gi];
          sync2_r[gi] <= sync1_r[gi];
        end
      end
    end
  endgenerate

  assign cmp = trs_cmp_s'(sync2_r[NSYNC-1:2]);
  assign trip_s = sync2_r[1];
  assign run_s = sync2_r[0];

  // ================================================
  // sequencing state machine
  trs_state_e state_r;
  trs_state_e state_nxt;

  // a rail's own fault sends the machine back to the step that brings it up,
  // so everything later drops while earlier rails keep running
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      TRS_OFF: begin
        state_nxt = TRS_REF;
      end
      TRS_REF: begin
        if (cmp.ref_ok) begin
          state_nxt = TRS_MAIN;
        end
      end
      TRS_MAIN: begin
        if (!cmp.ref_ok) begin
          state_nxt = TRS_REF;
        end else if (cmp.main_reg) begin
          state_nxt = TRS_NEG;
        end
      end
      TRS_NEG: begin
        if (!cmp.ref_ok) begin
          state_nxt = TRS_REF;
        end else if (cmp.main_fault) begin
          state_nxt = TRS_MAIN;
        end else if (cmp.neg_up) begin
          state_nxt = TRS_POS;
        end
      end
      TRS_POS: begin
        if (!cmp.ref_ok) begin
          state_nxt = TRS_REF;
        end else if (cmp.main_fault) begin
          state_nxt = TRS_MAIN;
        end else if (cmp.neg_fault) begin
          state_nxt = TRS_NEG;
        end else if (cmp.pos_up) begin
          state_nxt = TRS_READY;
        end
      end
      TRS_READY: begin
        if (!cmp.ref_ok) begin
          state_nxt = TRS_REF;
        end else if (cmp.main_fault) begin
          state_nxt = TRS_MAIN;
        end else if (cmp.neg_fault) begin
          state_nxt = TRS_NEG;
        end else if (cmp.pos_fault) begin
          state_nxt = TRS_POS;
        end
      end
      default: begin
        state_nxt = TRS_OFF;
      end
    endcase
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      state_r <= TRS_OFF;
    end else if (!run_s) begin
      state_r <= TRS_OFF;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign seq_state = state_r;

  // ================================================
  // rail enables, registered
  trs_en_s en_r;
  logic past_main;
  logic past_neg;
  logic past_pos;

  assign past_main = (state_r == TRS_NEG) || past_neg;
  assign past_neg = (state_r == TRS_POS) || past_pos;
  assign past_pos = (state_r == TRS_READY);

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      en_r <= '{ref_en: 1'b0, ref_ground: 1'b1, main_en: 1'b0, neg_en: 1'b0, pos_en: 1'b0};
    end else if (!run_s || state_nxt == TRS_OFF) begin
      en_r <= '{ref_en: 1'b0, ref_ground: 1'b1, main_en: 1'b0, neg_en: 1'b0, pos_en: 1'b0};
    end else begin
      en_r.ref_en <= 1'b1;
      en_r.ref_ground <= 1'b0;
      // boost waits one step behind the reference, also on leaving off
      en_r.main_en <= (state_r != TRS_REF) && (state_r != TRS_OFF);
      en_r.neg_en <= past_main;
      en_r.pos_en <= past_neg;
    end
  end

  assign rail_en = en_r;

  // ================================================
  // ready pin: open drain, pulled low only in the ready state
  logic ready_pull_r;

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      ready_pull_r <= `TRS_RDY_OFF;
    end else begin
      ready_pull_r <= run_s && past_pos && (state_nxt == TRS_READY);
    end
  end

  assign ready_n_o = 1'b0;
  assign ready_n_oe = ready_pull_r;

  // ================================================
  // boost oscillator and pwm latch
  logic [6:0] phase_r;
  logic osc_edge;
  logic sw_r;

  // phase counter runs even when idle so the pumps share its edge
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      phase_r <= 7'h0;
    end else if (phase_r == 7'(PERIOD - 1)) begin
      phase_r <= 7'h0;
    end else begin
      phase_r <= phase_r + 7'h1;
    end
  end

  assign osc_edge = (phase_r == 7'h0);

  // no soft-start on the boost: full duty from its first period
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      sw_r <= 1'b0;
    end else if (!en_r.main_en) begin
      sw_r <= 1'b0;
    end else if (osc_edge) begin
      sw_r <= 1'b1;
    end else if (trip_s || phase_r >= 7'(MAX_ON)) begin
      sw_r <= 1'b0;
    end
  end

  assign boost_switch_node = sw_r;

  // ================================================
  // pump phases at half the boost rate
  logic half_r;
  trs_pump_s gate_r;

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      half_r <= 1'b0;
    end else if (osc_edge) begin
      half_r <= ~half_r;
    end
  end

  // pump outputs are held off while disabled, which also clears the ramp to zero
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      gate_r <= '0;
    end else begin
      gate_r.neg_hi <= en_r.neg_en && !half_r;
      gate_r.neg_lo <= en_r.neg_en && half_r;
      gate_r.pos_lo <= en_r.pos_en && !half_r;
      gate_r.pos_hi <= en_r.pos_en && half_r;
    end
  end

  assign pump_gate = gate_r;
  assign neg_pump_drive = gate_r.neg_hi;
  assign pos_pump_drive = gate_r.pos_hi;

  // ================================================
  // soft-start of each pump
  trs_soft_start u_neg_soft (
    .clock(clock),
    .reset(reset),
    .enable(en_r.neg_en),
    .level(neg_pump_ramp),
    .done()
  );

  trs_soft_start u_pos_soft (
    .clock(clock),
    .reset(reset),
    .enable(en_r.pos_en),
    .level(pos_pump_ramp),
    .done()
  );
endmodule // trs_sequencer

// File: tb/trs_sequencer_chk.sv
// port checker for the triple rail sequencer
`timescale 1ns/1ps
module trs_sequencer_chk
  import trs_pkg::*;
(
  input wire logic clock,
  input wire logic reset,
  input wire logic shutdown_n,
  input wire logic boost_trip,
  input wire trs_en_s rail_en,
  input wire logic boost_switch_node,
  input wire trs_pump_s pump_gate,
  input wire logic neg_pump_drive,
  input wire logic pos_pump_drive,
  input wire logic ready_n_o,
  input wire logic ready_n_oe,
  input wire trs_state_e seq_state
);
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  logic [7:0] on_r;
  logic [15:0] gap_r;
  logic seen_r;
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      on_r <= 8'h00;
    end else begin
      on_r <= boost_switch_node ? on_r + 8'h01 : 8'h00;
    end
  end
  // gap from last rise; first rise has no reference
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      gap_r <= 16'h0000;
      seen_r <= 1'b0;
    end else begin
      gap_r <= $rose(boost_switch_node) ? 16'h0001 : gap_r + 16'h0001;
      seen_r <= seen_r | $rose(boost_switch_node);
    end
  end
  property p_off;
    !shutdown_n [*6] |-> rail_en == 5'h08 && seq_state == TRS_OFF;
  endproperty
  a_off: assert property (p_off) else $error("shutdown left a rail on");
  property p_gnd;
    rail_en.ref_ground == !rail_en.ref_en;
  endproperty
  a_gnd: assert property (p_gnd) else $error("reference ground wrong");
  property p_order;
    $rose(rail_en.main_en) |-> $past(rail_en.ref_en);
  endproperty
  a_order: assert property (p_order) else $error("boost before reference");
  property p_chain;
    rail_en.neg_en |-> rail_en.main_en && rail_en.ref_en;
  endproperty
  a_chain: assert property (p_chain) else $error("pump without boost");
  property p_rdy;
    ready_n_oe |-> seq_state == TRS_READY && !ready_n_o;
  endproperty
  a_rdy: assert property (p_rdy) else $error("ready outside ready state");
  property p_duty;
    on_r <= 8'h44;
  endproperty
  a_duty: assert property (p_duty) else $error("on-time above limit");
  property p_gap;
    $rose(boost_switch_node) && seen_r |-> gap_r % 16'h0050 == 16'h0000;
  endproperty
  a_gap: assert property (p_gap) else $error("switch period wrong");
  property p_trip;
    $rose(boost_trip) |-> ##[1:4] !boost_switch_node;
  endproperty
  a_trip: assert property (p_trip) else $error("trip ignored");
  property p_pump;
    !(pump_gate.neg_hi && pump_gate.neg_lo) && !(pump_gate.pos_hi && pump_gate.pos_lo);
  endproperty
  a_pump: assert property (p_pump) else $error("pump shoot-through");
  property p_drive;
    neg_pump_drive == pump_gate.neg_hi && pos_pump_drive == pump_gate.pos_hi;
  endproperty
  a_drive: assert property (p_drive) else $error("drive pin mismatch");
endmodule // trs_sequencer_chk

// File: tb/trs_rails.sv
// rail and host side model for the sequencer
`timescale 1ns/1ps
module trs_rails
  import trs_pkg::*;
(
  input wire logic clock,
  input wire logic reset,
  input wire trs_en_s rail_en,
  input wire logic [3:0] fault,
  input wire logic [7:0] trip_at,
  input wire logic boost_switch_node,
  input wire logic ready_n_o,
  input wire logic ready_n_oe,
  output trs_cmp_s cmp_in,
  output logic boost_trip,
  output wire logic ready_pin
);
  logic [7:0] on_r;
  // pull-up: a released line reads not good
  assign ready_pin = ready_n_oe ? ready_n_o : 1'b1;
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      on_r <= 8'h00;
    end else begin
      on_r <= boost_switch_node ? on_r + 8'h01 : 8'h00;
    end
  end
  // zero trip point lets the duty limit end the pulse
  assign boost_trip = (trip_at != 8'h00) && (on_r >= trip_at);
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      cmp_in <= '0;
    end else begin
      cmp_in.ref_ok <= rail_en.ref_en && !fault[0];
      cmp_in.main_reg <= rail_en.main_en && !fault[1];
      cmp_in.main_fault <= rail_en.main_en && fault[1];
      cmp_in.neg_up <= rail_en.neg_en && !fault[2];
      cmp_in.neg_fault <= rail_en.neg_en && fault[2];
      cmp_in.pos_up <= rail_en.pos_en && !fault[3];
      cmp_in.pos_fault <= rail_en.pos_en && fault[3];
    end
  end
endmodule // trs_rails

// File: tb/trs_sequencer_test.sv
// self-checking bench for the triple rail sequencer
`timescale 1ns/1ps
module trs_sequencer_test
  import trs_pkg::*;
;
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic shutdown_n = 1'b1;
  logic [3:0] fault = 4'h0;
  logic [7:0] trip_at = 8'h00;
  logic boost_trip, boost_switch_node, neg_pump_drive, pos_pump_drive;
  logic ready_n_o, ready_n_oe, ready_pin;
  logic [7:0] neg_pump_ramp, pos_pump_ramp;
  trs_cmp_s cmp_in;
  trs_en_s rail_en;
  trs_pump_s pump_gate;
  trs_state_e seq_state;
  int failures = 0;
  int compares = 0;
  int cyc = 0;
  int hi, per;
  always #25 clock = ~clock;
  trs_sequencer i_trs_sequencer (.clock(clock), .reset(reset), .shutdown_n(shutdown_n),
    .cmp_in(cmp_in), .boost_trip(boost_trip), .rail_en(rail_en),
    .boost_switch_node(boost_switch_node), .pump_gate(pump_gate),
    .neg_pump_ramp(neg_pump_ramp), .pos_pump_ramp(pos_pump_ramp),
    .neg_pump_drive(neg_pump_drive), .pos_pump_drive(pos_pump_drive),
    .ready_n_o(ready_n_o), .ready_n_oe(ready_n_oe), .seq_state(seq_state));
  trs_rails i_trs_rails (.clock(clock), .reset(reset), .rail_en(rail_en), .fault(fault),
    .trip_at(trip_at), .boost_switch_node(boost_switch_node), .ready_n_o(ready_n_o),
    .ready_n_oe(ready_n_oe), .cmp_in(cmp_in), .boost_trip(boost_trip),
    .ready_pin(ready_pin));
  // ==========
  // helpers
  task chk(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task conclude;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task wst(input trs_state_e s);
    for (int n = 0; n < 40 && seq_state !== s; n++) @(negedge clock);
  endtask
  function logic sig(input bit p);
    return p ? pump_gate.neg_hi : boost_switch_node;
  endfunction
  // high time and period of the next whole pulse
  task meas(input bit p);
    hi = 0;
    per = 0;
    for (int n = 0; n < 200 && sig(p) !== 1'b0; n++) @(negedge clock);
    for (int n = 0; n < 200 && sig(p) !== 1'b1; n++) @(negedge clock);
    while (sig(p) === 1'b1 && hi < 200) begin
      hi++;
      per++;
      @(negedge clock);
    end
    while (sig(p) === 1'b0 && per < 400) begin
      per++;
      @(negedge clock);
    end
  endtask
  // ==========
  // scenarios
  task t_seq;
    wst(TRS_POS);
    chk(seq_state, TRS_POS);
    chk(rail_en, 5'h16);
    wst(TRS_READY);
    chk(seq_state, TRS_READY);
    chk(ready_pin, 1'b1);
    @(negedge clock);
    chk(ready_pin, 1'b0);
    chk(rail_en, 5'h17);
    $display("sequence test done");
  endtask
  task t_pwm;
    meas(0);
    chk(hi, 8'h44);
    chk(per, 8'h50);
    trip_at = 8'h0a;
    meas(0);
    meas(0);
    chk(hi < 30, 1'b1);
    chk(per, 8'h50);
    trip_at = 8'h00;
    $display("pwm test done");
  endtask
  task t_pump;
    meas(1);
    chk(hi, 8'h50);
    chk(per, 8'ha0);
    repeat (100) @(negedge clock);
    chk(pump_gate.neg_lo, 1'b1);
    $display("pump test done");
  endtask
  task t_fault;
    fault = 4'h2;
    wst(TRS_MAIN);
    repeat (2) @(negedge clock);
    chk(rail_en, 5'h14);
    chk(ready_pin, 1'b1);
    fault = 4'h0;
    wst(TRS_NEG);
    chk(seq_state, TRS_NEG);
    fault = 4'h1;
    wst(TRS_REF);
    repeat (2) @(negedge clock);
    chk(rail_en, 5'h10);
    fault = 4'h0;
    wst(TRS_NEG);
    chk(seq_state, TRS_NEG);
    wst(TRS_READY);
    repeat (2) @(negedge clock);
    fault = 4'h8;
    wst(TRS_POS);
    chk(seq_state, TRS_POS);
    repeat (2) @(negedge clock);
    chk(ready_pin, 1'b1);
    chk(rail_en, 5'h17);
    fault = 4'h0;
    wst(TRS_READY);
    chk(seq_state, TRS_READY);
    $display("fault test done");
  endtask
  task t_shutdown_n;
    shutdown_n = 1'b0;
    repeat (6) @(negedge clock);
    chk(rail_en, 5'h08);
    chk(seq_state, TRS_OFF);
    shutdown_n = 1'b1;
    wst(TRS_REF);
    chk(seq_state, TRS_REF);
    wst(TRS_NEG);
    chk(seq_state, TRS_NEG);
    $display("shutdown test done");
  endtask
  // runs take about 1000 cycles
  always @(posedge clock) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      conclude;
    end
  end
  initial begin
    repeat (12) @(negedge clock);
    reset = 1'b0;
    t_seq;
    t_pwm;
    t_pump;
    t_fault;
    t_shutdown_n;
    conclude;
  end
endmodule // trs_sequencer_test
bind trs_sequencer trs_sequencer_chk i_trs_sequencer_chk (.*);
